// ---- src/rtci_top.sv ----
// Module: indirect access port to the clock's internal registers over Avalon-MM
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`default_nettype none
// Overview of operation
// - Index selects target of indirect accesses
// - Index bit 7 reads busy during access
// - Window write starts indirect write
// - Writing one to busy starts read
// - Window holds read value until next access
// - Index select, autoread, window survive device reset
// - Access takes 7 cycles, 6 short
// - Short strobe on after reset, bit 4
// - Autoread: window read starts next read
// - Autoread enabled by index bit 6
// - Timer is 32-bit, wraps freely
// - Auto-reset mode clears timer on alarm
module rtci_top import rtci_pkg::*; #(
  parameter int TICK_DIV = 6104
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        por_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  output logic             irq
);
  // ------------------------------------------------------------
  // Access, interrupt and timer registers
  // ------------------------------------------------------------
  rtci_state_type   state_reg, state_next;
  logic [2:0]       cnt_reg, cnt_next;
  logic [3:0]       sel_reg, sel_next;
  logic             auto_reg, auto_next;
  logic             short_reg, short_next;
  logic [7:0]       window_reg, window_next;
  logic             ack_reg, ack_next;
  logic [31:0]      rdata_reg, rdata_next;
  logic [1:0]       resp_reg, resp_next;
  logic [RTCI_IRQ_W-1:0] stat_reg, stat_next;
  logic [RTCI_IRQ_W-1:0] en_reg, en_next;
  logic [7:0]       ctl_reg, ctl_next;
  logic [7:0]       alarm_reg [4];
  logic [7:0]       alarm_next [4];
  logic [12:0]      div_reg, div_next;
  logic             tick;
  logic [31:0]      count;
  logic             alarm_pulse, wrap_pulse;
  logic             tload;
  logic [31:0]      tload_value;
  logic             busy;
  logic             wr_acc, rd_acc, done;
  logic [7:0]       iread;

  function automatic logic hit_off(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  assign busy   = (state_reg != RTCI_IDLE);
  assign wr_acc = avs_write && !ack_reg;
  assign rd_acc = avs_read && !ack_reg;
  assign done   = busy && (cnt_reg == 3'h1);
  assign tick   = (div_reg == 13'h0);

  // ------------------------------------------------------------
  // Internal register read mux
  // ------------------------------------------------------------
  always_comb begin
    iread = 8'h00;
    if (sel_reg < 4'h4) begin
      iread = count[8*sel_reg[1:0] +: 8];
    end else if (sel_reg == RTCI_IR_CONTROL) begin
      iread = ctl_reg;
    end else if (sel_reg >= RTCI_IR_ALARM0 && sel_reg < 4'hC) begin
      iread = alarm_reg[sel_reg[1:0]];
    end
  end

  // ------------------------------------------------------------
  // Bus slave and access engine
  // ------------------------------------------------------------
  always_comb begin
    state_next  = state_reg;
    cnt_next    = cnt_reg;
    sel_next    = sel_reg;
    auto_next   = auto_reg;
    short_next  = short_reg;
    window_next = window_reg;
    ack_next    = 1'b0;
    rdata_next  = rdata_reg;
    resp_next   = 2'b00;
    stat_next   = stat_reg;
    en_next     = en_reg;
    ctl_next    = ctl_reg;
    alarm_next  = alarm_reg;
    tload       = 1'b0;
    tload_value = count;
    if (done) begin
      state_next = RTCI_IDLE;
      if (state_reg == RTCI_READ) begin
        window_next = iread;
      end else if (sel_reg < 4'h4) begin
        tload = 1'b1;
        tload_value[8*sel_reg[1:0] +: 8] = window_reg;
      end else if (sel_reg == RTCI_IR_CONTROL) begin
        ctl_next = window_reg;
      end else if (sel_reg >= RTCI_IR_ALARM0 && sel_reg < 4'hC) begin
        alarm_next[sel_reg[1:0]] = window_reg;
      end
    end else if (busy) begin
      cnt_next = cnt_reg - 3'h1;
    end
    if (wr_acc || rd_acc) begin
      ack_next = 1'b1;
    end
    if (wr_acc && avs_byteenable[0]) begin
      if (hit_off(avs_address, {1'b0, RTCI_OFF_INDEX})) begin
        sel_next   = avs_writedata[RTCI_SEL_MSB:0];
        auto_next  = avs_writedata[RTCI_BIT_AUTO];
        short_next = avs_writedata[RTCI_BIT_SHORT];
        if (avs_writedata[RTCI_BIT_BUSY] && !busy) begin
          state_next = RTCI_READ;
          cnt_next   = avs_writedata[RTCI_BIT_SHORT] ? RTCI_CYC_SHORT : RTCI_CYC_LONG;
        end
      end else if (hit_off(avs_address, {1'b0, RTCI_OFF_WINDOW}) && !busy) begin
        window_next = avs_writedata[7:0];
        state_next  = RTCI_WRITE;
        cnt_next    = short_reg ? RTCI_CYC_SHORT : RTCI_CYC_LONG;
      end else if (hit_off(avs_address, {1'b0, RTCI_OFF_IRQ_CLR})) begin
        stat_next = stat_reg & ~avs_writedata[RTCI_IRQ_W-1:0];
      end else if (hit_off(avs_address, RTCI_OFF_IRQ_EN)) begin
        en_next = avs_writedata[RTCI_IRQ_W-1:0];
      end else if (!hit_off(avs_address, {1'b0, RTCI_OFF_WINDOW})
                   && !hit_off(avs_address, {1'b0, RTCI_OFF_IRQ_STAT})) begin
        resp_next = 2'b11;
      end
    end
    if (rd_acc) begin
      rdata_next = 32'h0;
      if (hit_off(avs_address, {1'b0, RTCI_OFF_INDEX})) begin
        rdata_next[RTCI_BIT_BUSY]   = busy;
        rdata_next[RTCI_BIT_AUTO]   = auto_reg;
        rdata_next[RTCI_BIT_SHORT]  = short_reg;
        rdata_next[RTCI_SEL_MSB:0]  = sel_reg;
      end else if (hit_off(avs_address, {1'b0, RTCI_OFF_WINDOW})) begin
        rdata_next[7:0] = window_reg;
        if (auto_reg && !busy) begin
          state_next = RTCI_READ;
          cnt_next   = short_reg ? RTCI_CYC_SHORT : RTCI_CYC_LONG;
        end
      end else if (hit_off(avs_address, {1'b0, RTCI_OFF_IRQ_STAT})) begin
        rdata_next[RTCI_IRQ_W-1:0] = stat_reg;
      end else if (hit_off(avs_address, RTCI_OFF_IRQ_EN)) begin
        rdata_next[RTCI_IRQ_W-1:0] = en_reg;
      end else if (!hit_off(avs_address, {1'b0, RTCI_OFF_IRQ_CLR})) begin
        resp_next = 2'b11;
      end
    end
    // Hardware set wins over software clear
    // Done is set after the clear write so a same-cycle clear loses
    if (done) begin
      stat_next[RTCI_IRQ_DONE] = 1'b1;
    end
    if (alarm_pulse) begin
      stat_next[RTCI_IRQ_ALARM] = 1'b1;
      ctl_next[RTCI_CTL_ALMF]   = 1'b1;
    end
    if (wrap_pulse) begin
      stat_next[RTCI_IRQ_WRAP] = 1'b1;
    end
    div_next = tick ? 13'(TICK_DIV - 1) : div_reg - 13'h1;
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  // Index select, autoread and window sit on the power-on reset only, so nrst leaves them intact; the short strobe resets with nrst
  always_ff @(posedge mclk or negedge por_n) begin
    if (!por_n) begin
      sel_reg    <= 4'h0;
      auto_reg   <= 1'b0;
      window_reg <= 8'h00;
    end else begin
      sel_reg    <= sel_next;
      auto_reg   <= auto_next;
      window_reg <= window_next;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= RTCI_IDLE;
      cnt_reg   <= 3'h0;
      short_reg <= 1'b1;
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
      resp_reg  <= 2'b00;
      stat_reg  <= '0;
      en_reg    <= '0;
      ctl_reg   <= RTCI_CTL_RESET;
      alarm_reg <= '{default: 8'h00};
      div_reg   <= 13'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      short_reg <= short_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      resp_reg  <= resp_next;
      stat_reg  <= stat_next;
      en_reg    <= en_next;
      ctl_reg   <= ctl_next;
      alarm_reg <= alarm_next;
      div_reg   <= div_next;
    end
  end

  // ------------------------------------------------------------
  // Clock timer
  // ------------------------------------------------------------
  // Loads go a byte at a time, so a running timer can tear mid-update
  rtci_timer #(.WIDTH(32)) u_timer (
    .mclk        (mclk),
    .nrst        (nrst),
    .tick        (tick),
    .run         (ctl_reg[RTCI_CTL_RUN]),
    .alarm_en    (ctl_reg[RTCI_CTL_ALMEN]),
    .auto_reset  (ctl_reg[RTCI_CTL_AUTOR]),
    .alarm_match ({alarm_reg[3], alarm_reg[2], alarm_reg[1], alarm_reg[0]}),
    .load        (tload),
    .load_value  (tload_value),
    .count       (count),
    .alarm_pulse (alarm_pulse),
    .wrap_pulse  (wrap_pulse)
  );

  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign avs_readdata    = rdata_reg;
  assign avs_response    = resp_reg;
  assign irq             = |(stat_reg & en_reg);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_busy_length: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(busy) && !short_reg |-> busy [*7] ##1 !busy)
    else $error("long access not seven cycles");
  a_short_length: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(busy) && short_reg |-> busy [*6] ##1 !busy)
    else $error("short access not six cycles");
  a_busy_read_start: assert property (@(posedge mclk) disable iff (!nrst)
    wr_acc && avs_byteenable[0] && avs_address == 5'h0 && avs_writedata[7] && !busy
    |=> state_reg == RTCI_READ)
    else $error("busy write did not start read");
  a_window_write: assert property (@(posedge mclk) disable iff (!nrst)
    wr_acc && avs_byteenable[0] && avs_address == 5'h4 && !busy |=> state_reg == RTCI_WRITE)
    else $error("window write did not start write");
  a_window_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !busy && !wr_acc |=> $stable(window_reg))
    else $error("window changed while idle");
  a_window_refused: assert property (@(posedge mclk) disable iff (!nrst)
    busy && !done && wr_acc && avs_address == 5'h4 |=> $stable(window_reg))
    else $error("window write taken while busy");
  a_autoread_go: assert property (@(posedge mclk) disable iff (!nrst)
    rd_acc && avs_address == 5'h4 && auto_reg && !busy |=> busy)
    else $error("autoread did not start");
  a_busy_readback: assert property (@(posedge mclk) disable iff (!nrst)
    rd_acc && avs_address == 5'h0 |=> avs_readdata[7] == $past(busy))
    else $error("busy bit readback wrong");
  a_read_copy: assert property (@(posedge mclk) disable iff (!nrst)
    done && state_reg == RTCI_READ |=> window_reg == $past(iread))
    else $error("read did not copy selected register");
  a_write_lands: assert property (@(posedge mclk) disable iff (!nrst)
    done && state_reg == RTCI_WRITE && sel_reg == RTCI_IR_CONTROL && !alarm_pulse
    |=> ctl_reg == $past(window_reg))
    else $error("write did not reach control register");
  a_index_hold: assert property (@(posedge mclk) disable iff (!nrst)
    !(wr_acc && avs_byteenable[0] && avs_address == 5'h0) |=> $stable(sel_reg) && $stable(auto_reg))
    else $error("index changed without a write");
  a_long_start: assert property (@(posedge mclk) disable iff (!nrst)
    wr_acc && avs_byteenable[0] && avs_address == 5'h4 && !busy && !short_reg |=> cnt_reg == RTCI_CYC_LONG)
    else $error("long access count wrong");
  a_done_status: assert property (@(posedge mclk) disable iff (!nrst)
    done |=> stat_reg[RTCI_IRQ_DONE])
    else $error("done status not set");
  a_alarm_status: assert property (@(posedge mclk) disable iff (!nrst)
    alarm_pulse |=> stat_reg[RTCI_IRQ_ALARM] && ctl_reg[RTCI_CTL_ALMF])
    else $error("alarm not recorded");
  a_short_reset: assert property (@(posedge mclk) $rose(nrst) |-> short_reg)
    else $error("short strobe not on after reset");
  c_read: cover property (@(posedge mclk) disable iff (!nrst) done && state_reg == RTCI_READ);
  c_write: cover property (@(posedge mclk) disable iff (!nrst) done && state_reg == RTCI_WRITE);
  c_auto: cover property (@(posedge mclk) disable iff (!nrst) rd_acc && auto_reg && avs_address == 5'h4);
  c_alarm: cover property (@(posedge mclk) disable iff (!nrst) alarm_pulse);
  c_wrap: cover property (@(posedge mclk) disable iff (!nrst) wrap_pulse);
endmodule
`default_nettype wire

// ---- src/rtci_pkg.sv ----
// Package: offsets, fields, reset values and timing of the clock indirect access block
`default_nettype none
package rtci_pkg;
  // Avalon word offsets (byte addresses)
  localparam logic [3:0] RTCI_OFF_INDEX    = 4'h0;
  localparam logic [3:0] RTCI_OFF_WINDOW   = 4'h4;
  localparam logic [3:0] RTCI_OFF_IRQ_STAT = 4'h8;
  localparam logic [3:0] RTCI_OFF_IRQ_CLR  = 4'hC;
  localparam logic [4:0] RTCI_OFF_IRQ_EN   = 5'h10;
  // Index register fields
  localparam int RTCI_BIT_BUSY  = 7;
  localparam int RTCI_BIT_AUTO  = 6;
  localparam int RTCI_BIT_SHORT = 4;
  localparam int RTCI_SEL_MSB   = 3;
  // Internal clock register map
  localparam logic [3:0] RTCI_IR_TIMER0   = 4'h0;
  localparam logic [3:0] RTCI_IR_CONTROL  = 4'h5;
  localparam logic [3:0] RTCI_IR_ALARM0   = 4'h8;
  localparam int         RTCI_NUM_IREGS   = 16;
  // Control register fields
  localparam int RTCI_CTL_RUN   = 0;
  localparam int RTCI_CTL_ALMEN = 1;
  localparam int RTCI_CTL_AUTOR = 2;
  localparam int RTCI_CTL_ALMF  = 3;
  // Access timing in system clocks
  localparam logic [2:0] RTCI_CYC_LONG  = 3'h7;
  localparam logic [2:0] RTCI_CYC_SHORT = 3'h6;
  // Reset values
  localparam logic [7:0] RTCI_CTL_RESET = 8'h00;
  // Interrupt status bits
  localparam int RTCI_IRQ_DONE  = 0;
  localparam int RTCI_IRQ_ALARM = 1;
  localparam int RTCI_IRQ_WRAP  = 2;
  localparam int RTCI_IRQ_W     = 3;
  typedef enum logic [1:0] {
    RTCI_IDLE  = 2'b00,
    RTCI_READ  = 2'b01,
    RTCI_WRITE = 2'b11
  } rtci_state_type;
endpackage
`default_nettype wire

// ---- src/rtci_timer.sv ----
// Module: 32-bit clock timer with alarm match, free-running or auto-reset
`default_nettype none
module rtci_timer import rtci_pkg::*; #(
  parameter int WIDTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             tick,
  input  wire logic             run,
  input  wire logic             alarm_en,
  input  wire logic             auto_reset,
  input  wire logic [WIDTH-1:0] alarm_match,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] count,
  output logic                  alarm_pulse,
  output logic                  wrap_pulse
);
  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic             alarm_reg;
  logic             alarm_next;
  logic             wrap_reg;
  logic             wrap_next;
  logic             hit;

  always_comb begin
    count_next = count_reg;
    hit        = run && tick && alarm_en && (count_reg == alarm_match);
    alarm_next = hit;
    wrap_next  = 1'b0;
    if (load) begin
      count_next = load_value;
    end else if (hit && auto_reset) begin
      count_next = '0;
    end else if (run && tick) begin
      count_next = count_reg + 1'b1;
      wrap_next  = &count_reg;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_reg <= '0;
      alarm_reg <= 1'b0;
      wrap_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      alarm_reg <= alarm_next;
      wrap_reg  <= wrap_next;
    end
  end

  assign count       = count_reg;
  assign alarm_pulse = alarm_reg;
  assign wrap_pulse  = wrap_reg;

  a_timer_autoclr: assert property (@(posedge mclk) disable iff (!nrst)
    (hit && auto_reset && !load) |=> (count_reg == '0))
    else $error("timer not cleared on auto-reset alarm");
  a_timer_wraps: assert property (@(posedge mclk) disable iff (!nrst)
    (run && tick && !load && !hit && (&count_reg)) |=> (count_reg == '0) && wrap_reg)
    else $error("timer did not wrap");
endmodule
`default_nettype wire

// ---- testbench/rtci_cpu.sv ----
// Processor model: Avalon-MM master issuing clock register accesses
`default_nettype none
module rtci_cpu import rtci_pkg::*; (
  input  wire logic        mclk,
  output logic      [4:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  input  wire logic [1:0]  avs_response,
  output logic             hung
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    hung = 1'b0;
  end

  // Enter right after a rising edge; returns one edge after release
  task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic [1:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    q = avs_readdata;
    r = avs_response;
    if (n == 50) hung = 1'b1;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask

  // Polls busy instead of relying on instruction spacing
  task automatic wait_idle();
    logic [31:0] q;
    logic [1:0]  r;
    int          n;
    n = 0;
    q = 32'h80;
    while (q[7] !== 1'b0 && n < 40) begin
      access(1'b0, {1'b0, RTCI_OFF_INDEX}, 32'h0, q, r);
      n++;
    end
    if (n == 40) hung = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Testbench: indirect access, timing, timer modes and interrupts of the clock block
`default_nettype none
module tb import rtci_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [4:0] off_idx = {1'b0, RTCI_OFF_INDEX};
  localparam logic [4:0] off_win = {1'b0, RTCI_OFF_WINDOW};
  localparam logic [4:0] off_sta = {1'b0, RTCI_OFF_IRQ_STAT};
  localparam logic [4:0] off_clr = {1'b0, RTCI_OFF_IRQ_CLR};
  localparam logic [4:0] off_en  = RTCI_OFF_IRQ_EN;
  logic        mclk = 1'b0;
  logic        nrst;
  logic        por_n;
  logic [4:0]  address;
  logic        read;
  logic        write;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic [1:0]  resp_w;
  logic        irq;
  logic        hung;
  logic [1:0]  resp;
  logic [31:0] q;
  logic [31:0] prev;
  int          t_long;
  int          t_short;
  int          changes;
  int          num_errors = 0;
  int          check_count = 0;

  always #2.5 mclk = ~mclk;

  rtci_top #(.TICK_DIV(4)) u_dut (.mclk(mclk), .nrst(nrst), .por_n(por_n), .avs_address(address),
    .avs_read(read), .avs_write(write), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .avs_response(resp_w), .irq(irq));
  rtci_cpu u_cpu (.mclk(mclk), .avs_address(address), .avs_read(read), .avs_write(write),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .avs_response(resp_w), .hung(hung));

  // ------------------------------
  // Access and check tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (hung) num_errors++;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] x;
    u_cpu.access(1'b1, a, {24'h0, d}, x, resp);
    if (hung) wrap_up();
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    u_cpu.access(1'b0, a, 32'h0, d, resp);
    if (hung) wrap_up();
  endtask
  task automatic idle();
    u_cpu.wait_idle();
    if (hung) wrap_up();
  endtask
  // Short strobe kept on; select in the low nibble
  task automatic iwr(input logic [3:0] s, input logic [7:0] d);
    idle();
    wr(off_idx, {4'h1, s});
    wr(off_win, d);
  endtask
  task automatic ird(input logic [3:0] s, output logic [31:0] d);
    idle();
    wr(off_idx, {4'h9, s});
    idle();
    rd(off_win, d);
  endtask
  // Done interrupt marks the end of the access; both lengths share the same offset
  task automatic timed_write(input logic [7:0] idx, output int n);
    idle();
    wr(off_clr, 8'h07);
    wr(off_idx, idx);
    wr(off_win, 8'h06);
    n = 0;
    while (irq !== 1'b1 && n < 30) begin
      @(posedge mclk);
      n++;
    end
    if (n == 30) begin
      chk("done interrupt", 32'h1, {31'h0, irq});
      wrap_up();
    end
  endtask

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    nrst = 1'b0;
    por_n = 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    @(posedge mclk);
    rd(off_idx, q);
    chk("index after reset", 32'h10, q & 32'hFFFF_FFF0);
    rd(5'h14, q);
    chk("unmapped response", 32'h3, {30'h0, resp});
    wr(off_en, 8'h01);
    timed_write(8'h05, t_long);
    timed_write(8'h15, t_short);
    chk("long minus short", 32'h1, 32'(t_long - t_short));
    chk("long access span", 32'h1, {31'h0, t_long inside {[4:9]}});
    wr(off_clr, 8'h01);
    @(posedge mclk);
    chk("irq after clear", 32'h0, {31'h0, irq});
    wr(off_en, 8'h00);
    wr(off_win, 8'h06);
    // Deliberately early window write: refused, control must stay 06
    wr(off_win, 8'h55);
    rd(off_idx, q);
    chk("busy during access", 32'h1, {31'h0, q[7]});
    idle();
    rd(off_idx, q);
    chk("busy self clear", 32'h0, {31'h0, q[7]});
    rd(off_sta, q);
    chk("done status masked", 32'h1, q & 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    iwr(4'h8, 8'h03);
    for (int i = 9; i < 12; i++) iwr(4'(i), 8'h00);
    ird(4'h5, q);
    chk("control read back", 32'h06, q);
    wr(off_idx, 8'h18);
    rd(off_win, q);
    chk("window held", 32'h06, q);
    // Short strobe read with fixed spacing instead of polling
    wr(off_idx, 8'h98);
    repeat (4) @(posedge mclk);
    rd(off_win, q);
    chk("read without polling", 32'h03, q);
    ird(4'h8, q);
    chk("alarm match read", 32'h03, q);
    // Auto-reset mode, sampled through autoread with uneven spacing
    iwr(4'h5, 8'h07);
    idle();
    wr(off_clr, 8'h07);
    wr(off_idx, 8'hD0);
    changes = 0;
    prev = 32'h0;
    for (int i = 0; i < 12; i++) begin
      idle();
      rd(off_win, q);
      chk("timer within alarm", 32'h1, {31'h0, q <= 32'h3});
      if (i > 0 && q !== prev) changes++;
      prev = q;
      repeat (i) @(posedge mclk);
    end
    chk("autoread refresh", 32'h1, {31'h0, changes > 2});
    rd(off_sta, q);
    chk("alarm status", 32'h2, q & 32'h2);
    // Free-running wrap from just below the top
    iwr(4'h5, 8'h00);
    iwr(4'h0, 8'hFE);
    for (int i = 1; i < 4; i++) iwr(4'(i), 8'hFF);
    idle();
    wr(off_clr, 8'h07);
    iwr(4'h5, 8'h01);
    repeat (40) @(posedge mclk);
    rd(off_sta, q);
    chk("wrap status", 32'h4, q & 32'h4);
    iwr(4'h5, 8'h00);
    ird(4'h3, q);
    chk("timer top byte", 32'h00, q);
    // Device reset alone must leave index select, autoread and window intact; short strobe returns to one
    ird(4'h8, q);
    wr(off_idx, 8'h48);
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(off_idx, q);
    chk("index through reset", 32'h58, q);
    rd(off_win, q);
    chk("window through reset", 32'h03, q);
    wrap_up();
  end
endmodule
`default_nettype wire
